// ==== hdl/gpio_pkg.sv ====
/*
 * gpio_pkg: register map, widths and reset values for the two-port
 * parallel i/o block.
 * assumes: apb slave with 32-bit data, one register per aligned word.
 */
package gpio_pkg;
   // ************************************************************
   // register indices (printed offsets) and chosen indices
   // ************************************************************
   localparam logic [7:0] IDX_PA_LATCH  = 8'h00;  // port a data
   localparam logic [7:0] IDX_PB_LATCH  = 8'h01;  // port b data
   localparam logic [7:0] IDX_PA_DIR    = 8'h04;  // port a direction
   localparam logic [7:0] IDX_PB_DIR    = 8'h05;  // port b direction
   localparam logic [7:0] IDX_PA_PULLUP = 8'h08;  // port a pullup enable
   localparam logic [7:0] IDX_MUX_CTRL  = 8'h0C;  // peripheral sharing control
   localparam int         BYTE_SHIFT    = 2;      // byte address = index * 4
   // ************************************************************
   // widths
   // ************************************************************
   localparam int PA_W = 5;
   localparam int PB_W = 8;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [PA_W-1:0] PA_DIR_RST    = 5'h00;
   localparam logic [PB_W-1:0] PB_DIR_RST    = 8'h00;
   localparam logic [PA_W-1:0] PA_PULLUP_RST = 5'h00;
   // ************************************************************
   // pin positions of shared functions
   // ************************************************************
   localparam int PA_TIMER_CHANNEL_ZERO_PIN = 2;  // timer channel zero pin
   localparam int PA_TIMER_CHANNEL_ONE_PIN = 3;  // timer channel one pin
   localparam int PB_TXD  = 0;  // serial transmit pin
   localparam int PB_RXD  = 1;  // serial receive pin
   localparam int PB_CKI  = 6;  // external clock input pin
   localparam int PB_CKO  = 7;  // external clock output pin
   localparam int ADC_PIN_BASE = 2;  // analog channels on pins 2..5
   localparam int ADC_CHANS    = 4;
   // mux control bit positions
   localparam int MUX_CKO_BIT = 0;
   localparam int MUX_CKI_BIT = 1;
endpackage : gpio_pkg

// ==== hdl/gpio_pin.sv ====
/*
 * gpio_pin: one pin's direction, latch and pin read selection.
 * assumes: an override from a peripheral takes priority over port control.
 */
`timescale 1ns/1ps
`default_nettype none
module gpio_pin (
   input  wire logic latch,       // software data latch
   input  wire logic dir,         // 1 = output
   input  wire logic pin_in,      // sampled pin level
   input  wire logic ovr_en,      // peripheral owns the pin
   input  wire logic ovr_oe,      // peripheral output enable
   input  wire logic ovr_out,     // peripheral output level
   output logic      pin_out,     // pad output value
   output logic      pin_oe,      // pad output enable
   output logic      read_val     // value seen by a port read
);
   // ************************************************************
   // pad drive and read path
   // ************************************************************
   // direction bit enables the buffer unless a peripheral owns it
   assign pin_oe   = ovr_en ? ovr_oe : dir;
   assign pin_out  = ovr_en ? ovr_out : latch;
   // output pins read back the latch, input pins the pad level
   assign read_val = dir ? latch : pin_in;
endmodule : gpio_pin
`default_nettype wire

// ==== hdl/two_port_parallel_io.sv ====
/*
 * two_port_parallel_io: five-pin port a and eight-pin port b with data
 * latches, direction bits, port a pullups and peripheral pin sharing.
 * assumes: apb master on ref_clk; pins already synchronous; peripherals
 * supply their enables and output levels as plain inputs.
 */
// Register access over APB was left to the implementer.
// Behaviour
// - port a five latches, untouched by reset
// - port b eight latches, untouched by reset
// - direction one drives pin, zero input
// - reset clears all direction bits
// - port a read: latch if output, pin otherwise
// - port b read: latch if output, pin otherwise
// - data writes always update latches
// - pullup bit connects the port a pullup
// - pullup forced off on output pins
// - serial disabled returns its pins to gpio
// - selected analog channel forces pin input
// - timer edge/level bits claim timer pins
// - keypad enable makes pin a wake input
// - clock pins taken when configured
`timescale 1ns/1ps
`default_nettype none
module two_port_parallel_io
   import gpio_pkg::*;
#(
   parameter int PA_WIDTH = PA_W,
   parameter int PB_WIDTH = PB_W
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic      [31:0]         prdata,
   // port a pads
   input  wire logic [PA_WIDTH-1:0] pa_in,
   output logic      [PA_WIDTH-1:0] pa_out,
   output logic      [PA_WIDTH-1:0] pa_oe,
   output logic      [PA_WIDTH-1:0] pa_pullup_on,
   // port b pads
   input  wire logic [PB_WIDTH-1:0] pb_in,
   output logic      [PB_WIDTH-1:0] pb_out,
   output logic      [PB_WIDTH-1:0] pb_oe,
   // keypad sharing
   input  wire logic [PA_WIDTH-1:0] keypad_irq_pin_enable,
   output logic      [PA_WIDTH-1:0] keypad_wake_input,
   // timer sharing
   input  wire logic [1:0]          timer_edge_level_sel_a,
   input  wire logic [1:0]          timer_edge_level_sel_b,
   input  wire logic [1:0]          timer_chan_oe,
   input  wire logic [1:0]          timer_chan_out,
   output logic                     timer_channel_zero_pin,
   output logic                     timer_channel_one_pin,
   // serial sharing
   input  wire logic                serial_if_enable,
   input  wire logic                serial_tx_data,
   output logic                     serial_rx_data,
   // analog converter sharing
   input  wire logic                adc_chan_valid,
   input  wire logic [1:0]          adc_chan_sel,
   // clock generator sharing, then the analog pin active flag
   input  wire logic                clkgen_out_enable,
   input  wire logic                clkgen_in_enable,
   input  wire logic                clkgen_clock_out,
   output logic                     external_clock_input,
   output logic                     analog_pin_active
);
   // ************************************************************
   // register state
   // ************************************************************
   logic [PA_WIDTH-1:0] port_a_pin_latch;      // no reset by design
   logic [PB_WIDTH-1:0] port_b_pin_latch;      // no reset by design
   logic [PA_WIDTH-1:0] port_a_direction;      // 1 = output
   logic [PB_WIDTH-1:0] port_b_direction;      // 1 = output
   logic [PA_WIDTH-1:0] port_a_pullup_enable;  // 1 = pullup wanted
   logic [1:0]          mux_ctrl;              // clock pin selection

   // ************************************************************
   // apb decode
   // ************************************************************
   wire  [9:0] word_idx  = paddr[11:BYTE_SHIFT];
   wire        aligned   = (paddr[BYTE_SHIFT-1:0] == 2'h0);
   wire        hit_pa    = aligned && (word_idx == {2'h0, IDX_PA_LATCH});
   wire        hit_pb    = aligned && (word_idx == {2'h0, IDX_PB_LATCH});
   wire        hit_pad   = aligned && (word_idx == {2'h0, IDX_PA_DIR});
   wire        hit_pbd   = aligned && (word_idx == {2'h0, IDX_PB_DIR});
   wire        hit_pu    = aligned && (word_idx == {2'h0, IDX_PA_PULLUP});
   wire        hit_mux   = aligned && (word_idx == {2'h0, IDX_MUX_CTRL});
   wire        mapped    = hit_pa | hit_pb | hit_pad | hit_pbd | hit_pu | hit_mux;
   wire        access    = psel & penable;
   wire        wr_en     = access & pwrite & mapped;

   // zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // ************************************************************
   // pin sharing decisions
   // ************************************************************
   logic [PA_WIDTH-1:0] pa_ovr_en;   // peripheral owns port a pin
   logic [PA_WIDTH-1:0] pa_ovr_oe;
   logic [PA_WIDTH-1:0] pa_ovr_out;
   logic [PB_WIDTH-1:0] pb_ovr_en;   // peripheral owns port b pin
   logic [PB_WIDTH-1:0] pb_ovr_oe;
   logic [PB_WIDTH-1:0] pb_ovr_out;
   logic [PA_WIDTH-1:0] pa_read;
   logic [PB_WIDTH-1:0] pb_read;
   logic [PB_WIDTH-1:0] adc_onehot;  // pin claimed by the converter
   wire  [1:0]          timer_owns = timer_edge_level_sel_a | timer_edge_level_sel_b;

   always_comb begin
      // defaults: port logic owns every pin
      pa_ovr_en  = '0;
      pa_ovr_oe  = '0;
      pa_ovr_out = '0;
      pb_ovr_en  = '0;
      pb_ovr_oe  = '0;
      pb_ovr_out = '0;
      adc_onehot = '0;
      // timer channels sit on pins 2 and 3 of port a
      pa_ovr_en[PA_TIMER_CHANNEL_ZERO_PIN]  = timer_owns[0];
      pa_ovr_oe[PA_TIMER_CHANNEL_ZERO_PIN]  = timer_chan_oe[0];
      pa_ovr_out[PA_TIMER_CHANNEL_ZERO_PIN] = timer_chan_out[0];
      pa_ovr_en[PA_TIMER_CHANNEL_ONE_PIN]  = timer_owns[1];
      pa_ovr_oe[PA_TIMER_CHANNEL_ONE_PIN]  = timer_chan_oe[1];
      pa_ovr_out[PA_TIMER_CHANNEL_ONE_PIN] = timer_chan_out[1];
      // serial owns its pins only while enabled
      pb_ovr_en[PB_TXD]  = serial_if_enable;
      pb_ovr_oe[PB_TXD]  = serial_if_enable;
      pb_ovr_out[PB_TXD] = serial_tx_data;
      pb_ovr_en[PB_RXD]  = serial_if_enable;
      // clock pins need both configuration and generator enable
      pb_ovr_en[PB_CKO]  = mux_ctrl[MUX_CKO_BIT] & clkgen_out_enable;
      pb_ovr_oe[PB_CKO]  = 1'b1;
      pb_ovr_out[PB_CKO] = clkgen_clock_out;
      pb_ovr_en[PB_CKI]  = mux_ctrl[MUX_CKI_BIT] & clkgen_in_enable;
      // converter wins last: it forces a plain input
      if (adc_chan_valid) begin
         adc_onehot[ADC_PIN_BASE + int'(adc_chan_sel)] = 1'b1;
      end
      pb_ovr_en  = pb_ovr_en | adc_onehot;
      pb_ovr_oe  = pb_ovr_oe & ~adc_onehot;
   end

   // ************************************************************
   // per-pin drive and read selection
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < PA_WIDTH; gi++) begin : g_pa
         gpio_pin u_pin (
            .latch    (port_a_pin_latch[gi]),
            .dir      (port_a_direction[gi]),
            .pin_in   (pa_in[gi]),
            .ovr_en   (pa_ovr_en[gi]),
            .ovr_oe   (pa_ovr_oe[gi]),
            .ovr_out  (pa_ovr_out[gi]),
            .pin_out  (pa_out[gi]),
            .pin_oe   (pa_oe[gi]),
            .read_val (pa_read[gi])
         );
      end
      for (gi = 0; gi < PB_WIDTH; gi++) begin : g_pb
         gpio_pin u_pin (
            .latch    (port_b_pin_latch[gi]),
            .dir      (port_b_direction[gi]),
            .pin_in   (pb_in[gi]),
            .ovr_en   (pb_ovr_en[gi]),
            .ovr_oe   (pb_ovr_oe[gi]),
            .ovr_out  (pb_ovr_out[gi]),
            .pin_out  (pb_out[gi]),
            .pin_oe   (pb_oe[gi]),
            .read_val (pb_read[gi])
         );
      end
   endgenerate

   // pullup only on pins that are inputs by direction
   assign pa_pullup_on = port_a_pullup_enable & ~port_a_direction;

   // keypad sees the pad level on every enabled pin
   assign keypad_wake_input      = pa_in & keypad_irq_pin_enable;
   assign timer_channel_zero_pin = pa_in[PA_TIMER_CHANNEL_ZERO_PIN];
   assign timer_channel_one_pin  = pa_in[PA_TIMER_CHANNEL_ONE_PIN];
   // idle high while the serial block is off
   assign serial_rx_data         = serial_if_enable ? pb_in[PB_RXD] : 1'b1;
   assign external_clock_input   = pb_ovr_en[PB_CKI] & pb_in[PB_CKI];
   assign analog_pin_active      = |adc_onehot;

   // ************************************************************
   // read mux: upper bits read as zero
   // ************************************************************
   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = '0;
      if (hit_pa)  next_prdata[PA_WIDTH-1:0] = pa_read;
      if (hit_pb)  next_prdata[PB_WIDTH-1:0] = pb_read;
      if (hit_pad) next_prdata[PA_WIDTH-1:0] = port_a_direction;
      if (hit_pbd) next_prdata[PB_WIDTH-1:0] = port_b_direction;
      if (hit_pu)  next_prdata[PA_WIDTH-1:0] = port_a_pullup_enable;
      if (hit_mux) next_prdata[1:0]          = mux_ctrl;
   end
   // read data registered in setup so it stands ready for the access edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // ************************************************************
   // data latches: no reset, a write always lands
   // ************************************************************
   // the latches keep their content across reset on purpose
   always_ff @(posedge ref_clk) begin
      if (wr_en && hit_pa) begin
         port_a_pin_latch <= pwdata[PA_WIDTH-1:0];
      end
      if (wr_en && hit_pb) begin
         port_b_pin_latch <= pwdata[PB_WIDTH-1:0];
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   // software should load a latch before turning its pin to output
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         port_a_direction     <= PA_DIR_RST;
         port_b_direction     <= PB_DIR_RST;
         port_a_pullup_enable <= PA_PULLUP_RST;
         mux_ctrl             <= 2'h0;
      end else if (wr_en) begin
         if (hit_pad) port_a_direction     <= pwdata[PA_WIDTH-1:0];
         if (hit_pbd) port_b_direction     <= pwdata[PB_WIDTH-1:0];
         if (hit_pu)  port_a_pullup_enable <= pwdata[PA_WIDTH-1:0];
         if (hit_mux) mux_ctrl             <= pwdata[1:0];
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   AST_DIR_RESET: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> (port_a_direction == '0) && (port_b_direction == '0))
      else $error("direction not cleared by reset");
   AST_PULLUP_OFF_OUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (pa_pullup_on & port_a_direction) == '0)
      else $error("pullup on for output pin");
   AST_PULLUP_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_en && hit_pu) |=> pa_pullup_on == ($past(pwdata[PA_WIDTH-1:0]) & ~port_a_direction))
      else $error("pullup state wrong");
   AST_PA_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_en && hit_pa) |=> port_a_pin_latch == $past(pwdata[PA_WIDTH-1:0]))
      else $error("port a latch not written");
   AST_PB_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_en && hit_pb) |=> port_b_pin_latch == $past(pwdata[PB_WIDTH-1:0]))
      else $error("port b latch not written");
   AST_PA_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (psel && !penable && !pwrite && hit_pa) |=>
         prdata[PA_WIDTH-1:0] == $past((port_a_direction & port_a_pin_latch) | (~port_a_direction & pa_in)))
      else $error("port a read wrong");
   AST_PA_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (psel && !penable && !pwrite && (hit_pa || hit_pad || hit_pu)) |=> prdata[31:PA_WIDTH] == '0)
      else $error("port a upper bits nonzero");
   AST_SERIAL_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!serial_if_enable && !adc_onehot[PB_TXD]) |-> pb_oe[PB_TXD] == port_b_direction[PB_TXD])
      else $error("serial pin not released");
   AST_ADC_INPUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (pb_oe & adc_onehot) == '0)
      else $error("analog pin driven");
   // ************************************************************
   // read and pin sharing checks
   // ************************************************************
   // setup step of a port b read; its data stands at the access edge
   sequence pb_read_setup;
      psel && !penable && !pwrite && hit_pb;
   endsequence
   AST_PB_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pb_read_setup |=>
         prdata == 32'($past((port_b_direction & port_b_pin_latch) | (~port_b_direction & pb_in))))
      else $error("port b read wrong");
   // either select pair hands pin 3 to the timer's drive enable
   AST_TIMER_PIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (timer_edge_level_sel_a[1] || timer_edge_level_sel_b[1]) |-> pa_oe[PA_TIMER_CHANNEL_ONE_PIN] == timer_chan_oe[1])
      else $error("timer pin not taken");
   // the clock output pin follows the generator once both gates are open
   AST_CLK_OUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mux_ctrl[MUX_CKO_BIT] && clkgen_out_enable) |-> pb_oe[PB_CKO] && (pb_out[PB_CKO] == clkgen_clock_out))
      else $error("clock pin not driven");
   // a disabled serial block sees an idle line, never the pad
   AST_RX_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !serial_if_enable |-> serial_rx_data)
      else $error("receive line not idle");
endmodule : two_port_parallel_io
`default_nettype wire

// ==== verif/pad_model.sv ====
/*
 * pad_model: the board around the two ports; resolves each pad from the
 * block's drive, the port a pullups and outside drivers.
 * assumes: pad outputs are combinational; port b has no pullups.
 */
`timescale 1ns/1ps
`default_nettype none
module pad_model (
   input  wire logic       ref_clk,      // bench clock for the float pattern
   input  wire logic [4:0] pa_out,       // block drive value, port a
   input  wire logic [4:0] pa_oe,        // block drive enable, port a
   input  wire logic [4:0] pa_pullup_on, // pullup connected, port a
   input  wire logic [4:0] ext_a,        // outside level, port a
   input  wire logic [4:0] ext_en_a,     // outside device drives port a
   input  wire logic [7:0] pb_out,       // block drive value, port b
   input  wire logic [7:0] pb_oe,        // block drive enable, port b
   input  wire logic [7:0] ext_b,        // outside level, port b
   output logic      [4:0] pa_in,        // pad level seen, port a
   output logic      [7:0] pb_in         // pad level seen, port b
);
   // ************************************************************
   // pad resolution
   // ************************************************************
   // floating pads toggle so a stale value never passes for a read
   logic [4:0] flt = 5'h0A;
   always @(posedge ref_clk) begin
      flt <= ~flt;
   end
   // block drive wins, then outside driver, then pullup
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_en_a & ext_a) |
                  (~pa_oe & ~ext_en_a & (pa_pullup_on | flt & ~pa_pullup_on));
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
endmodule : pad_model
`default_nettype wire

// ==== verif/test_two_port_parallel_io.sv ====
/*
 * test_two_port_parallel_io: random and corner checks of the two ports.
 * assumes: zero wait-state apb slave, read data captured at setup edge.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module test_two_port_parallel_io;
   import gpio_pkg::*;
   // ************************************************************
   // signals
   // ************************************************************
   logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] pa_in, pa_out, pa_oe, pa_pullup_on, keypad_irq_pin_enable, keypad_wake_input;
   logic [4:0] ext_a, ext_en_a, la, da, pu, exp_a;
   logic [7:0] pb_in, pb_out, pb_oe, ext_b, lb, db;
   logic [1:0] timer_edge_level_sel_a, timer_edge_level_sel_b, timer_chan_oe, timer_chan_out, adc_chan_sel;
   logic serial_if_enable, serial_tx_data, serial_rx_data, adc_chan_valid, analog_pin_active;
   logic clkgen_out_enable, clkgen_in_enable, clkgen_clock_out, external_clock_input;
   logic timer_channel_zero_pin, timer_channel_one_pin, err;
   int   errors = 0;  // mismatches
   int   checks = 0;  // comparisons made
   two_port_parallel_io uut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .pslverr, .prdata, .pa_in, .pa_out, .pa_oe, .pa_pullup_on, .pb_in, .pb_out, .pb_oe,
      .keypad_irq_pin_enable, .keypad_wake_input, .timer_edge_level_sel_a, .timer_edge_level_sel_b,
      .timer_chan_oe, .timer_chan_out, .timer_channel_zero_pin, .timer_channel_one_pin,
      .serial_if_enable, .serial_tx_data, .serial_rx_data, .adc_chan_valid, .adc_chan_sel,
      .clkgen_out_enable, .clkgen_in_enable, .clkgen_clock_out, .external_clock_input,
      .analog_pin_active);
   pad_model pads (.ref_clk, .pa_out, .pa_oe, .pa_pullup_on, .ext_a, .ext_en_a, .pb_out, .pb_oe,
      .ext_b, .pa_in, .pb_in);
   // 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // ************************************************************
   // bus tasks
   // ************************************************************
   function automatic logic [11:0] ad(input logic [7:0] idx);
      return 12'(idx) << BYTE_SHIFT;
   endfunction : ad
   // one transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // read and compare the bits named in mask
   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      `CHK(nm, ex & m, rd & m)
   endtask : rdchk
   task automatic test_done;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   // watchdog; the sequence needs about 820 cycles
   initial begin
      #(4 * 8000);
      errors++;
      test_done();
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
      {keypad_irq_pin_enable, timer_edge_level_sel_a, timer_edge_level_sel_b, timer_chan_oe} = '0;
      {timer_chan_out, serial_if_enable, serial_tx_data, adc_chan_valid, adc_chan_sel} = '0;
      {clkgen_out_enable, clkgen_in_enable, clkgen_clock_out, ext_a, ext_en_a, ext_b} = '0;
      void'($urandom(86415));
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      `CHK("pa_oe", 5'h00, pa_oe)
      `CHK("pb_oe", 8'h00, pb_oe)
      rdchk("dir_a", ad(IDX_PA_DIR), 32'(PA_DIR_RST), '1);
      rdchk("dir_b", ad(IDX_PB_DIR), 32'(PB_DIR_RST), '1);
      rdchk("pullup", ad(IDX_PA_PULLUP), 32'(PA_PULLUP_RST), '1);
      // unmapped word refused
      apb(1'b0, 12'h0FC, 32'h0);
      `CHK("slverr", 1'b1, err)
      apb(1'b1, ad(IDX_PA_DIR), 32'hFFFF_FFE0);
      rdchk("dir_a_hi", ad(IDX_PA_DIR), 32'h0, '1);
      // random configurations; latch loaded before direction
      repeat (24) begin
         {la, da, pu} = 15'($urandom);
         {lb, db} = 16'($urandom);
         @(posedge ref_clk);
         {ext_a, ext_en_a, keypad_irq_pin_enable} <= 15'($urandom);
         ext_b <= 8'($urandom);
         apb(1'b1, ad(IDX_PA_LATCH), $urandom | 32'h0000_00E0);
         rdchk("latch_a", ad(IDX_PA_LATCH), 32'h0, 32'hFFFF_FFE0);
         apb(1'b1, ad(IDX_PA_LATCH), 32'(la));
         apb(1'b1, ad(IDX_PB_LATCH), 32'(lb));
         apb(1'b1, ad(IDX_PA_PULLUP), 32'(pu));
         apb(1'b1, ad(IDX_PA_DIR), 32'(da));
         apb(1'b1, ad(IDX_PB_DIR), 32'(db));
         @(negedge ref_clk);
         `CHK("pa_oe", da, pa_oe)
         `CHK("pb_oe", db, pb_oe)
         `CHK("pa_out", la & da, pa_out & da)
         `CHK("pb_out", lb & db, pb_out & db)
         `CHK("pullup_on", pu & ~da, pa_pullup_on)
         `CHK("kbd_wake", pa_in & keypad_irq_pin_enable, keypad_wake_input)
         exp_a = (da & la) | (~da & ext_en_a & ext_a) | (~da & ~ext_en_a & pu);
         rdchk("read_a", ad(IDX_PA_LATCH), 32'(exp_a), 32'(da | ext_en_a | pu));
         rdchk("read_b", ad(IDX_PB_LATCH), 32'((db & lb) | (~db & ext_b)), '1);
         rdchk("dir_b_rb", ad(IDX_PB_DIR), 32'(db), '1);
      end
      // second reset keeps the latches
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      `CHK("pa_oe_rst", 5'h00, pa_oe)
      apb(1'b1, ad(IDX_PA_DIR), 32'h1F);
      apb(1'b1, ad(IDX_PB_DIR), 32'hFF);
      rdchk("keep_a", ad(IDX_PA_LATCH), 32'(la), '1);
      rdchk("keep_b", ad(IDX_PB_LATCH), 32'(lb), '1);
      // serial owns pins 0 and 1, then releases them
      serial_if_enable <= 1'b1;
      serial_tx_data <= ~lb[PB_TXD];
      @(negedge ref_clk);
      `CHK("tx_pin", {2'b01, ~lb[PB_TXD]}, {pb_oe[PB_RXD], pb_oe[PB_TXD], pb_out[PB_TXD]})
      `CHK("rx_data", pb_in[PB_RXD], serial_rx_data)
      @(posedge ref_clk);
      serial_if_enable <= 1'b0;
      @(negedge ref_clk);
      `CHK("tx_free", {2'b11, lb[PB_TXD]}, {pb_oe[PB_RXD], pb_oe[PB_TXD], pb_out[PB_TXD]})
      `CHK("rx_idle", 1'b1, serial_rx_data)
      // each converter channel forces its pin to input
      for (int s = 0; s < ADC_CHANS; s++) begin
         @(posedge ref_clk);
         adc_chan_valid <= 1'b1;
         adc_chan_sel <= 2'(s);
         @(negedge ref_clk);
         `CHK("adc_oe", 8'hFF & ~(8'h1 << (ADC_PIN_BASE + s)), pb_oe)
         `CHK("adc_act", 1'b1, analog_pin_active)
      end
      @(posedge ref_clk);
      adc_chan_valid <= 1'b0;
      // timer takes its two pins through either select pair
      timer_edge_level_sel_a <= 2'b01;
      timer_edge_level_sel_b <= 2'b10;
      timer_chan_oe <= 2'b01;
      timer_chan_out <= {1'b0, ~la[PA_TIMER_CHANNEL_ZERO_PIN]};
      @(negedge ref_clk);
      `CHK("tch_oe", 2'b01, {pa_oe[PA_TIMER_CHANNEL_ONE_PIN], pa_oe[PA_TIMER_CHANNEL_ZERO_PIN]})
      `CHK("timer_channel_zero_pin_out", ~la[PA_TIMER_CHANNEL_ZERO_PIN], pa_out[PA_TIMER_CHANNEL_ZERO_PIN])
      `CHK("tch_in", {pa_in[PA_TIMER_CHANNEL_ONE_PIN], pa_in[PA_TIMER_CHANNEL_ZERO_PIN]}, {timer_channel_one_pin, timer_channel_zero_pin})
      @(posedge ref_clk);
      timer_edge_level_sel_a <= 2'b00;
      timer_edge_level_sel_b <= 2'b00;
      // clock pins taken only when both selected and enabled
      clkgen_out_enable <= 1'b1;
      clkgen_in_enable <= 1'b1;
      clkgen_clock_out <= ~lb[PB_CKO];
      @(negedge ref_clk);
      `CHK("cko_off", {2'b11, lb[PB_CKO]}, {pb_oe[PB_CKO], pb_oe[PB_CKI], pb_out[PB_CKO]})
      apb(1'b1, ad(IDX_MUX_CTRL), 32'h3);
      @(negedge ref_clk);
      `CHK("cko", {2'b10, ~lb[PB_CKO]}, {pb_oe[PB_CKO], pb_oe[PB_CKI], pb_out[PB_CKO]})
      `CHK("cki", pb_in[PB_CKI], external_clock_input)
      `CHK("pa_oe_free", 5'h1F, pa_oe)
      repeat (2) @(posedge ref_clk);
      test_done();
   end
endmodule : test_two_port_parallel_io
`default_nettype wire
